//--- inc/dws_pkg.sv
// shared types and constants of the write-sequencing memory controller
package dws_pkg;
   // timing of the system clock and of the memory link
   localparam int CLK_PS = 25000;         // 40 MHz system clock period
   localparam int XSNR_NS = 200;          // self_refresh_exit_nonread_delay, ns
   localparam int XSRD_CK = 200;          // self_refresh_exit_read_delay, link clocks
   localparam int AOFD_CK = 3;            // termination_off_delay, link clocks
   // register word indices on the avalon slave
   localparam logic [2:0] REG_CMD = 3'h0;
   localparam logic [2:0] REG_CFG = 3'h1;
   localparam logic [2:0] REG_WDATA = 3'h2;
   localparam logic [2:0] REG_STAT = 3'h3;
   localparam int STAT_CLR_BIT = 2;       // write one clears the refused flag
   // burst geometry in link clocks and beats
   localparam logic [5:0] HALF_BURST_8 = 6'h04;
   localparam logic [5:0] HALF_BURST_4 = 6'h02;
   localparam logic [5:0] INT_SLOT = 6'h02;
   localparam logic [3:0] BEATS_8 = 4'h8;
   localparam logic [3:0] BEATS_4 = 4'h4;
   localparam int AP_ADDR_BIT = 10;       // auto precharge / all banks address line
   localparam int WSTART_W = 16;

   typedef enum logic [2:0] {OP_NOP, OP_ACT, OP_WRITE, OP_READ, OP_PRE, OP_SRE, OP_SRX} dws_op_t;
   typedef enum logic {ST_RUN, ST_SELFREF} dws_state_t;

   // chip select, row strobe, column strobe, write enable, all active low
   typedef struct packed {
      logic cs_b;
      logic ras_b;
      logic cas_b;
      logic we_b;
   } dws_pins_t;
   localparam dws_pins_t PIN_NOP = 4'h7;
   localparam dws_pins_t PIN_ACT = 4'h3;
   localparam dws_pins_t PIN_WRITE = 4'h4;
   localparam dws_pins_t PIN_READ = 4'h5;
   localparam dws_pins_t PIN_PRE = 4'h2;
   localparam dws_pins_t PIN_REFRESH = 4'h1;

   typedef struct packed {
      logic [12:0] addr;
      logic intr;
      logic ap;
      logic [1:0] bank;
      dws_op_t op;
   } dws_cmd_t;

   typedef struct packed {
      logic term_en;
      logic [2:0] write_to_read_delay;
      logic [2:0] write_recovery_time;
      logic [2:0] additive_latency;
      logic [2:0] cas_latency;
      logic burst8;
   } dws_cfg_t;
   localparam dws_cfg_t CFG_RESET = 14'h2987;

   typedef struct packed {
      logic [7:0] dq_sample;
      logic [3:0] open;
      logic term;
      logic fifo_empty;
      logic refused;
      logic in_sr;
      logic pending;
   } dws_stat_t;

   typedef struct packed {
      logic mask;
      logic [7:0] data;
   } dws_beat_t;
endpackage : dws_pkg

//--- logic/dws_tick.sv
// divider giving a one-cycle enable pulse every DIV system clocks
`timescale 1ns/1ps
module dws_tick
   import dws_pkg::*;
#(
   parameter int DIV = 2
) (
   input wire logic clock,
   input wire logic rst_b,
   output logic tick
);
   logic [7:0] cnt_q, cnt_d;
   logic tick_q, tick_d;

   // count down and pulse on wrap
   always_comb begin
      tick_d = (cnt_q == 8'h00);
      cnt_d = (cnt_q == 8'h00) ? 8'(DIV - 1) : cnt_q - 8'h01;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 8'h00;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;
endmodule : dws_tick

//--- logic/dws_fifo.sv
// write data fifo with valid/ready on both sides
`timescale 1ns/1ps
module dws_fifo
   import dws_pkg::*;
#(
   parameter int W = 9,
   parameter int DEPTH = 8
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wr_q, wr_d, rd_q, rd_d;
   logic push, pop;

   // extra pointer bit tells full from empty
   always_comb begin
      in_ready = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
      out_valid = (wr_q != rd_q);
      push = in_valid && in_ready;
      pop = out_ready && out_valid;
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
      out_data = mem[rd_q[AW-1:0]];
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end

   // storage has no reset; empty flag guards stale words
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end
endmodule : dws_fifo

//--- logic/dws_ctrl.sv
// write-burst sequencing controller driving a ddr2 memory, avalon-mm control
//
// Overview of operation
// R1: write to read waits cas-1, half burst, turnaround
// R2: back-to-back writes every half burst clocks
// R3: interrupt only programmed 8-beat write bursts
// R4: only a write may cut a write
// R5: interrupting write exactly two clocks after previous
// R6: device accepts interrupting write to any bank
// R7: never interrupt a write with auto precharge
// R8: device accepts auto-precharge write as interrupter
// R9: spacing counts from programmed burst length only
// R10: write to precharge: latency, half burst, recovery
// R11: all banks precharged before self refresh entry
// R12: termination off before entry, back after delay
// R13: exit delays: read one, others another
// R14: device skips bytes whose mask is high
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ps
module dws_ctrl
   import dws_pkg::*;
#(
   parameter int CK_DIV = 2,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic dram_ck,
   output logic dram_cke,
   output dws_pins_t dram_cmd,
   output logic [1:0] dram_ba,
   output logic [12:0] dram_addr,
   output logic dram_on_die_termination_ctl,
   input wire logic [7:0] dram_dq_i,
   output logic [7:0] dram_dq_o,
   output logic dram_dq_oe,
   output logic dram_dqs_o,
   output logic dram_dqs_oe,
   output logic dram_write_byte_mask
);
   localparam int LINK_PS = CLK_PS * 2 * CK_DIV;
   localparam int XSNR_CK = (XSNR_NS * 1000 + LINK_PS - 1) / LINK_PS;

   logic tick, fk, req, acc, can, go, refuse, illegal, ready_go, start;
   logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
   dws_beat_t f_out;
   dws_stat_t stat;
   logic [5:0] half, cas6, wlat, gap_wr_rd, gap_wr_pre;
   logic [3:0] wl_idx;
   dws_state_t state_q, state_d;
   dws_cmd_t cmd_q, cmd_d;
   dws_cfg_t cfg_q, cfg_d;
   dws_pins_t pins_q, pins_d;
   logic pend_q, pend_d, refused_q, refused_d, wait_q, wait_d;
   logic ck_q, ck_d, cke_q, cke_d, term_q, term_d, intok_q, intok_d;
   logic [1:0] ba_q, ba_d;
   logic [12:0] addr_q, addr_d;
   logic [3:0] open_q, open_d;
   logic [31:0] rdata_q, rdata_d;
   logic [5:0] col_q, col_d, wrrd_q, wrrd_d, wrpre_q, wrpre_d, toff_q, toff_d;
   logic [9:0] xsnr_q, xsnr_d, xsrd_q, xsrd_d;
   logic [WSTART_W-1:0] wstart_q, wstart_d;
   logic [3:0] beats_q, beats_d;
   logic [7:0] dq_q, dq_d, dq_s1_q, dq_s2_q;
   logic oe_q, oe_d, mask_q, mask_d, dqs_q, dqs_d;

   dws_tick #(.DIV(CK_DIV)) u_tick (
      .clock(clock),
      .rst_b(rst_b),
      .tick(tick)
   );

   dws_fifo #(.W($bits(dws_beat_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .rst_b(rst_b),
      .in_valid(f_in_valid),
      .in_ready(f_in_ready),
      .in_data(avs_writedata[$bits(dws_beat_t)-1:0]),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data(f_out)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // link clock phase and latency arithmetic from the programmed mode
   always_comb begin
      fk = tick && ck_q; // falling edge: commands settle before next rising edge
      half = cfg_q.burst8 ? HALF_BURST_8 : HALF_BURST_4; // see R9
      cas6 = {3'h0, cfg_q.cas_latency};
      wlat = {3'h0, cfg_q.additive_latency} + cas6 - 6'h01;
      gap_wr_rd = cas6 - 6'h01 + half + {3'h0, cfg_q.write_to_read_delay}; // see R1
      gap_wr_pre = wlat + half + {3'h0, cfg_q.write_recovery_time}; // see R10
      wl_idx = 4'(wlat - 6'h01);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // avalon slave: one wait cycle, more for a command write while a command is pending or a data write while the fifo is full; effect at the edge waitrequest is low
   always_comb begin
      req = avs_read || avs_write;
      acc = req && !wait_q;
      can = !(avs_write && ((avs_address == REG_CMD && pend_q)
            || (avs_address == REG_WDATA && !f_in_ready))); // full fifo stalls the bus
      f_in_valid = acc && avs_write && avs_address == REG_WDATA;
      stat = '{dq_sample: dq_s2_q, open: open_q, term: term_q, fifo_empty: !f_out_valid,
               refused: refused_q, in_sr: state_q == ST_SELFREF, pending: pend_q};
      wait_d = !(req && wait_q && can);
      rdata_d = rdata_q;
      if (req && wait_q && can) begin
         case (avs_address)
            REG_CMD: rdata_d = 32'(cmd_q);
            REG_CFG: rdata_d = 32'(cfg_q);
            REG_STAT: rdata_d = 32'(stat);
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // legality and readiness of the pending command
   always_comb begin
      illegal = 1'b0;
      ready_go = 1'b0;
      case (cmd_q.op)
         OP_ACT: begin
            illegal = state_q == ST_SELFREF || open_q[cmd_q.bank];
            ready_go = xsnr_q == 10'h000; // see R13
         end
         OP_WRITE: begin
            illegal = state_q == ST_SELFREF || !open_q[cmd_q.bank];
            if (cmd_q.intr) begin
               // only a full 8-beat plain write may be cut, any target bank
               illegal = illegal || !cfg_q.burst8 || !intok_q || col_q < INT_SLOT; // see R3
               ready_go = col_q == INT_SLOT && xsnr_q == 10'h000; // see R5
            end else begin
               ready_go = col_q == 6'h00 && xsnr_q == 10'h000; // see R2
            end
         end
         OP_READ: begin
            illegal = state_q == ST_SELFREF || !open_q[cmd_q.bank];
            ready_go = col_q == 6'h00 && wrrd_q == 6'h00 && xsrd_q == 10'h000; // see R4
         end
         OP_PRE: begin
            illegal = state_q == ST_SELFREF;
            ready_go = wrpre_q == 6'h00 && col_q == 6'h00 && xsnr_q == 10'h000; // see R10
         end
         OP_SRE: begin
            illegal = state_q == ST_SELFREF || open_q != 4'h0; // see R11
            ready_go = !term_q && toff_q >= 6'(AOFD_CK) && xsnr_q == 10'h000; // see R12, R13
         end
         OP_SRX: begin
            illegal = state_q != ST_SELFREF;
            ready_go = 1'b1;
         end
         default: begin
            ready_go = 1'b1;
         end
      endcase
      go = pend_q && fk && !illegal && ready_go;
      refuse = pend_q && fk && illegal;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // command sequencer next state
   always_comb begin
      state_d = state_q;
      cmd_d = cmd_q;
      cfg_d = cfg_q;
      pend_d = pend_q && !go && !refuse;
      refused_d = refused_q;
      ck_d = tick ? !ck_q : ck_q;
      cke_d = cke_q;
      pins_d = fk ? PIN_NOP : pins_q; // each command lasts one link clock
      ba_d = ba_q;
      addr_d = addr_q;
      open_d = open_q;
      intok_d = intok_q;
      // spacing counters run down once per link clock
      col_d = (fk && col_q != 6'h00) ? col_q - 6'h01 : col_q;
      wrrd_d = (fk && wrrd_q != 6'h00) ? wrrd_q - 6'h01 : wrrd_q;
      wrpre_d = (fk && wrpre_q != 6'h00) ? wrpre_q - 6'h01 : wrpre_q;
      xsnr_d = (fk && xsnr_q != 10'h000) ? xsnr_q - 10'h001 : xsnr_q;
      xsrd_d = (fk && xsrd_q != 10'h000) ? xsrd_q - 10'h001 : xsrd_q;
      if (acc && avs_write) begin
         case (avs_address)
            REG_CMD: begin
               cmd_d = dws_cmd_t'(avs_writedata[$bits(dws_cmd_t)-1:0]);
               pend_d = 1'b1;
            end
            REG_CFG: cfg_d = dws_cfg_t'(avs_writedata[$bits(dws_cfg_t)-1:0]);
            REG_STAT: begin
               if (avs_writedata[STAT_CLR_BIT]) begin
                  refused_d = 1'b0;
               end
            end
            default: ;
         endcase
      end
      if (refuse) begin
         refused_d = 1'b1; // set wins over a clear in the same cycle
      end
      if (go) begin
         ba_d = cmd_q.bank;
         addr_d = cmd_q.addr;
         case (cmd_q.op)
            OP_ACT: begin
               pins_d = PIN_ACT;
               open_d[cmd_q.bank] = 1'b1;
            end
            OP_WRITE: begin
               pins_d = PIN_WRITE;
               addr_d[AP_ADDR_BIT] = cmd_q.ap; // see R8
               col_d = half - 6'h01; // full programmed burst, even when cut; see R9
               wrrd_d = gap_wr_rd - 6'h01; // see R1
               wrpre_d = gap_wr_pre - 6'h01; // see R10
               intok_d = !cmd_q.ap; // see R7
               if (cmd_q.ap) begin
                  open_d[cmd_q.bank] = 1'b0;
               end
            end
            OP_READ: begin
               pins_d = PIN_READ;
               addr_d[AP_ADDR_BIT] = cmd_q.ap;
               col_d = half - 6'h01;
               intok_d = 1'b0; // see R4
               if (cmd_q.ap) begin
                  open_d[cmd_q.bank] = 1'b0;
               end
            end
            OP_PRE: begin
               pins_d = PIN_PRE;
               addr_d[AP_ADDR_BIT] = cmd_q.ap;
               if (cmd_q.ap) begin
                  open_d = 4'h0;
               end else begin
                  open_d[cmd_q.bank] = 1'b0;
               end
            end
            OP_SRE: begin
               pins_d = PIN_REFRESH;
               cke_d = 1'b0;
               state_d = ST_SELFREF;
            end
            OP_SRX: begin
               cke_d = 1'b1;
               state_d = ST_RUN;
               xsnr_d = 10'(XSNR_CK - 1); // see R13
               xsrd_d = 10'(XSRD_CK - 1); // see R13
            end
            default: ;
         endcase
      end
      // termination drops while entry waits, returns after the read exit delay
      term_d = cfg_q.term_en && state_q == ST_RUN && xsrd_q == 10'h000
               && !(pend_q && cmd_q.op == OP_SRE); // see R12
      toff_d = term_q ? 6'h00 : ((fk && toff_q != 6'h3F) ? toff_q + 6'h01 : toff_q);
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_RUN;
         cmd_q <= '0;
         cfg_q <= CFG_RESET;
         pend_q <= 1'b0;
         refused_q <= 1'b0;
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
         ck_q <= 1'b0;
         cke_q <= 1'b1;
         pins_q <= PIN_NOP;
         ba_q <= 2'h0;
         addr_q <= 13'h0000;
         open_q <= 4'h0;
         intok_q <= 1'b0;
         term_q <= 1'b0;
         toff_q <= 6'h00;
         col_q <= 6'h00;
         wrrd_q <= 6'h00;
         wrpre_q <= 6'h00;
         xsnr_q <= 10'h000;
         xsrd_q <= 10'h000;
      end else begin
         state_q <= state_d;
         cmd_q <= cmd_d;
         cfg_q <= cfg_d;
         pend_q <= pend_d;
         refused_q <= refused_d;
         wait_q <= wait_d;
         rdata_q <= rdata_d;
         ck_q <= ck_d;
         cke_q <= cke_d;
         pins_q <= pins_d;
         ba_q <= ba_d;
         addr_q <= addr_d;
         open_q <= open_d;
         intok_q <= intok_d;
         term_q <= term_d;
         toff_q <= toff_d;
         col_q <= col_d;
         wrrd_q <= wrrd_d;
         wrpre_q <= wrpre_d;
         xsnr_q <= xsnr_d;
         xsrd_q <= xsrd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // write data path: a new burst start truncates the running one
   always_comb begin
      wstart_d = fk ? {wstart_q[WSTART_W-2:0], go && cmd_q.op == OP_WRITE} : wstart_q;
      start = fk && wstart_q[wl_idx];
      f_out_ready = tick && beats_q != 4'h0;
      beats_d = beats_q;
      dq_d = dq_q;
      oe_d = oe_q;
      mask_d = mask_q;
      dqs_d = dqs_q;
      if (tick) begin
         oe_d = beats_q != 4'h0;
         dqs_d = (beats_q != 4'h0) && !dqs_q;
         mask_d = 1'b0;
         if (beats_q != 4'h0) begin
            dq_d = f_out.data;
            mask_d = f_out.mask || !f_out_valid; // an underrun beat is masked off
            beats_d = beats_q - 4'h1;
         end
      end
      if (start) begin
         beats_d = cfg_q.burst8 ? BEATS_8 : BEATS_4;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wstart_q <= '0;
         beats_q <= 4'h0;
         dq_q <= 8'h00;
         oe_q <= 1'b0;
         mask_q <= 1'b0;
         dqs_q <= 1'b0;
         dq_s1_q <= 8'h00;
         dq_s2_q <= 8'h00;
      end else begin
         wstart_q <= wstart_d;
         beats_q <= beats_d;
         dq_q <= dq_d;
         oe_q <= oe_d;
         mask_q <= mask_d;
         dqs_q <= dqs_d;
         dq_s1_q <= dram_dq_i; // pin sampled through two flops
         dq_s2_q <= dq_s1_q;
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign dram_ck = ck_q;
   assign dram_cke = cke_q;
   assign dram_cmd = pins_q;
   assign dram_ba = ba_q;
   assign dram_addr = addr_q;
   assign dram_on_die_termination_ctl = term_q;
   assign dram_dq_o = dq_q;
   assign dram_dq_oe = oe_q;
   assign dram_dqs_o = dqs_q;
   assign dram_dqs_oe = oe_q;
   assign dram_write_byte_mask = mask_q;

   ////////////////////////////////////////////////////////////////////////////////
   // checks: link clocks since the last write and since self refresh exit
   logic [5:0] since_wr_q;
   logic [9:0] since_srx_q;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         since_wr_q <= 6'h3F;
         since_srx_q <= 10'h3FF;
      end else if (fk) begin
         since_wr_q <= (go && cmd_q.op == OP_WRITE) ? 6'h01
                       : (since_wr_q == 6'h3F ? since_wr_q : since_wr_q + 6'h01);
         since_srx_q <= (go && cmd_q.op == OP_SRX) ? 10'h001
                        : (since_srx_q == 10'h3FF ? since_srx_q : since_srx_q + 10'h001);
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);

   property p_wr_rd; go && cmd_q.op == OP_READ |-> since_wr_q >= gap_wr_rd; endproperty
   a_wr_rd: assert property (p_wr_rd) else $error("read too soon after write"); // see R1
   property p_seamless; go && cmd_q.op == OP_WRITE |-> since_wr_q >= INT_SLOT; endproperty
   a_seamless: assert property (p_seamless) else $error("writes closer than two"); // see R2
   property p_cut_len; go && cmd_q.op == OP_WRITE && since_wr_q < half |-> cfg_q.burst8;
   endproperty
   a_cut_len: assert property (p_cut_len) else $error("short burst interrupted"); // see R3
   property p_cut_kind; go && (cmd_q.op == OP_READ || cmd_q.op == OP_PRE) |-> since_wr_q >= half;
   endproperty
   a_cut_kind: assert property (p_cut_kind) else $error("write cut by non-write"); // see R4
   property p_cut_slot; go && cmd_q.op == OP_WRITE && since_wr_q < half |-> since_wr_q == INT_SLOT;
   endproperty
   a_cut_slot: assert property (p_cut_slot) else $error("interrupt off slot"); // see R5
   property p_cut_ap; go && cmd_q.op == OP_WRITE && since_wr_q < half |-> intok_q; endproperty
   a_cut_ap: assert property (p_cut_ap) else $error("auto precharge burst cut"); // see R7
   property p_reload; go && cmd_q.op == OP_WRITE |=> col_q == half - 6'h01; endproperty
   a_reload: assert property (p_reload) else $error("spacing not from full burst"); // see R9
   property p_wr_pre; go && cmd_q.op == OP_PRE |-> since_wr_q >= gap_wr_pre; endproperty
   a_wr_pre: assert property (p_wr_pre) else $error("precharge too soon"); // see R10
   property p_sre_idle; go && cmd_q.op == OP_SRE |=> open_q == 4'h0 && !dram_cke; endproperty
   a_sre_idle: assert property (p_sre_idle) else $error("entry with open bank"); // see R11
   property p_term; (go && cmd_q.op == OP_SRE |-> toff_q >= 6'(AOFD_CK))
      and ($rose(term_q) |-> since_srx_q >= 10'(XSRD_CK)); endproperty
   a_term: assert property (p_term) else $error("termination timing broken"); // see R12
   property p_exit; go && cmd_q.op != OP_SRX |-> since_srx_q >= (cmd_q.op == OP_READ ?
      10'(XSRD_CK) : 10'(XSNR_CK)); endproperty
   a_exit: assert property (p_exit) else $error("command too soon after exit"); // see R13
endmodule : dws_ctrl

//--- verif/dws_ddr_model.sv
// ddr2 device model: command log and stored write beats
`timescale 1ns/1ps
module dws_ddr_model
   import dws_pkg::*;
(
   input wire logic clock,
   input wire logic ck,
   input wire logic cke,
   input wire dws_pins_t cmd,
   input wire logic [1:0] ba,
   input wire logic [12:0] ad,
   input wire logic on_die_termination_ctl,
   input wire logic [7:0] dq,
   input wire logic oe,
   input wire logic dqs,
   input wire logic dm,
   output logic [7:0] dqi
);
   int n = 0, t_exit = 0, t_off = 0;
   logic cke_p = 1'b1, odt_p = 1'b0, oe_p = 1'b0, dqs_p = 1'b0;
   logic [3:0] open_q = 4'h0;
   dws_pins_t q_pin[$];
   int q_t[$];
   logic [7:0] q_inf[$], q_dat[$];
   initial dqi = 8'h5A;
   ////////////////////////////////////////
   // commands on rising ck, any bank and write kind
   always @(posedge ck) begin
      n++;
      if (cke && !cke_p) t_exit = n;
      if (odt_p && !on_die_termination_ctl) t_off = n;
      cke_p = cke;
      odt_p = on_die_termination_ctl;
      if (cmd !== PIN_NOP) begin
         q_pin.push_back(cmd);
         q_t.push_back(n);
         q_inf.push_back({on_die_termination_ctl, 3'h0, open_q});
         if (cmd === PIN_ACT) open_q[ba] = 1'b1;
         if (cmd === PIN_PRE || (cmd === PIN_WRITE && ad[10])) open_q[ba] = 1'b0;
         if (cmd === PIN_PRE && ad[10]) open_q = 4'h0;
      end
   end
   ////////////////////////////////////////
   // one beat per dqs change; masked bytes untouched
   always @(posedge clock) begin
      if (oe && !dm && (dqs !== dqs_p || !oe_p)) q_dat.push_back(dq);
      dqs_p = dqs;
      oe_p = oe;
      dqi <= ~dqi;   // never a stale value
   end
endmodule : dws_ddr_model

//--- verif/ddr2_write_burst_sequencing_tb_top.sv
// bench: avalon stimulus, device model, spacing and beat checks
`timescale 1ns/1ps
module ddr2_write_burst_sequencing_tb_top
   import dws_pkg::*;
;
   logic clock = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [2:0] adr = 3'h0;
   logic [31:0] wd = 32'h0, rdat, r;
   logic wrq, ck, cke, on_die_termination_ctl, oe, dqs, dm, dqs_oe;
   dws_pins_t cmd;
   logic [1:0] ba;
   logic [12:0] ad;
   logic [7:0] dq, dqi, b;
   int fails = 0, n_tests = 0, seed = 39;
   logic [7:0] q_exp[$];
   // act act wr wr wr rd wr pre act act wr wr pre sr act rd
   localparam logic [63:0] PINS = 64'h3344454233442135;
   int w2r = CFG_RESET.cas_latency - 1 + HALF_BURST_8 + CFG_RESET.write_to_read_delay;
   int w2p = CFG_RESET.additive_latency + CFG_RESET.cas_latency - 1 + HALF_BURST_8
      + CFG_RESET.write_recovery_time;
   int xsnr = (XSNR_NS * 1000 + CLK_PS * 4 - 1) / (CLK_PS * 4);   // link is clock/4
   always #12.5 clock = ~clock;
   dws_ctrl u_dws_ctrl (.clock, .rst_b, .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wrq), .dram_ck(ck),
      .dram_cke(cke), .dram_cmd(cmd), .dram_ba(ba), .dram_addr(ad), .dram_dq_i(dqi),
      .dram_on_die_termination_ctl(on_die_termination_ctl), .dram_dq_o(dq), .dram_dq_oe(oe),
      .dram_dqs_o(dqs), .dram_dqs_oe(dqs_oe), .dram_write_byte_mask(dm));
   dws_ddr_model u_dws_ddr_model (.clock, .ck, .cke, .cmd, .ba, .ad, .on_die_termination_ctl, .dq, .oe,
      .dqs, .dm, .dqi);
   // strobe must be driven exactly while the data beats are
   always @(posedge clock) if (rst_b && dqs_oe !== oe) chk(dqs_oe, oe, "strobe enable");
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
      n_tests++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk
   // held until waitrequest is seen low; a stalled slave ends in a hang report
   task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clock);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      do begin
         @(posedge clock);
         k++;
      end while (wrq !== 1'b0 && k < 3000);
      r = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      chk(k < 3000, 1, "bus hang");
   endtask : av
   // command words, then a nop to drain them and a status read
   task automatic cmds(input logic [7:0] c[$]);
      foreach (c[k]) av(1'b1, REG_CMD, {24'h0, c[k]});
      av(1'b1, REG_CMD, 0);
      av(1'b0, REG_STAT, 0);
   endtask : cmds
   function automatic int t(input int k);
      return u_dws_ddr_model.q_t[k];
   endfunction : t
   task automatic final_report;
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report
   ////////////////////////////////////////
   // main sequence
   initial begin
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      av(1'b0, REG_CFG, 0);
      chk(r, 32'(CFG_RESET), "cfg reset");
      av(1'b1, 3'h6, 32'hFFFF);
      av(1'b0, 3'h6, 0);
      chk(r, 0, "unmapped");
      for (int i = 0; i < 8; i++) begin
         b = 8'($random(seed));
         av(1'b1, REG_WDATA, {23'h0, i == 3, b});
         if (i != 3) q_exp.push_back(b);
      end
      cmds('{8'h01, 8'h09, 8'h02, 8'h0A, 8'h42, 8'h03, 8'h0A, 8'h24});
      chk(t(3) - t(2), 32'(HALF_BURST_8), "seamless");
      chk(t(4) - t(3), 32'(INT_SLOT), "cut spacing");
      chk(t(5) - t(4) >= w2r, 1, "wr to rd");
      chk(t(7) - t(6) >= w2p, 1, "wr to pre");
      cmds('{8'h11, 8'h19, 8'h32, 8'h5A});
      chk(r[2], 1, "ap burst cut");
      av(1'b1, REG_STAT, 32'h4);
      av(1'b1, REG_CFG, 32'(CFG_RESET) - 1);   // burst of four
      cmds('{8'h1A, 8'h5A});
      chk(r[2], 1, "short burst cut");
      cmds('{8'h24, 8'h05});
      chk({r[1], cke}, 2'b10, "self refresh");
      cmds('{8'h06, 8'h01, 8'h03});
      chk(u_dws_ddr_model.q_inf[13], 0, "entry state");
      chk(t(13) - u_dws_ddr_model.t_off >= AOFD_CK, 1, "odt lead");
      chk(u_dws_ddr_model.q_inf[14][7], 0, "odt early");
      chk(t(14) - u_dws_ddr_model.t_exit >= xsnr, 1, "exit other");
      chk(t(15) - u_dws_ddr_model.t_exit >= XSRD_CK, 1, "exit read");
      for (int k = 0; k < 16; k++) chk(u_dws_ddr_model.q_pin[k], PINS[60 - 4 * k +: 4], "cmd");
      chk(u_dws_ddr_model.q_pin.size(), 16, "cmd count");
      chk(u_dws_ddr_model.q_dat.size(), q_exp.size(), "beats");
      foreach (q_exp[k]) chk(u_dws_ddr_model.q_dat[k], q_exp[k], "beat");
      final_report();
   end
   // watchdog well beyond the expected run
   initial begin
      repeat (20000) @(posedge clock);
      chk(0, 1, "watchdog");
      final_report();
   end
endmodule : ddr2_write_burst_sequencing_tb_top
